// file: rtl/correlator_top.sv
// Samplers, coarse delay, multipliers and integrating counters for up
// to twelve antennas, with a FIFO read-out toward the controller.
// Assumes all inputs are synchronous to clk_sys, one sample per clock.
`timescale 1ns/1ps
`default_nettype none
module correlator_top #(
    parameter int INTEG_CYCLE_CLKS = corr_pkg::INTEG_CLKS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Quantiser inputs, index antenna*4 + channel
    input wire logic [corr_pkg::NUM_ANT*corr_pkg::NUM_CH-1:0][corr_pkg::SAMPLE_W-1:0] cos_sample,
    input wire logic [corr_pkg::NUM_ANT*corr_pkg::NUM_CH-1:0][corr_pkg::SAMPLE_W-1:0] sin_sample,
    input wire logic [corr_pkg::NUM_ANT*corr_pkg::NUM_CH-1:0][corr_pkg::RMS_W-1:0] rms_level,
    input wire logic [corr_pkg::NUM_ANT-1:0] walsh_reverse,
    // Delay loading from the controller
    input wire logic delay_load,
    input wire logic [corr_pkg::ANT_IDX_W-1:0] delay_ant,
    input wire logic [corr_pkg::SAMP_PTR_W-1:0] delay_coarse,
    input wire logic [corr_pkg::PHASE_W-1:0] delay_fine,
    // Fine phase toward the sampler clock shifters
    output logic [corr_pkg::NUM_ANT-1:0][corr_pkg::PHASE_W-1:0] sampler_phase,
    // Counter read-out
    output logic dump_valid,
    output logic dump_first,
    output logic [corr_pkg::CNT_W-1:0] dump_data,
    input wire logic dump_ready,
    output logic dump_overrun
);
    import corr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Delay settings.

    logic [NUM_ANT-1:0][SAMP_PTR_W-1:0] coarse;
    wire load_ok = delay_load && (delay_ant < ANT_IDX_W'(NUM_ANT));
    wire [SAMP_PTR_W-1:0] coarse_lim =
        (delay_coarse > DELAY_MAX) ? DELAY_MAX : delay_coarse;

    // Loads take effect on the next clock; out-of-range antennas are ignored.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            coarse <= '0;
            sampler_phase <= '0;
        end else if (load_ok) begin
            coarse[delay_ant] <= coarse_lim;
            sampler_phase[delay_ant] <= delay_fine;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Samplers and retiming.

    logic [NUM_ANT-1:0][ANT_W-1:0] sampled;
    logic [NUM_ANT-1:0][ANT_W-1:0] retimed;
    logic [NUM_ANT-1:0][ANT_W-1:0] next_sampled;

    // Each channel yields four bits: cosine code over sine code.
    always_comb begin
        for (int a = 0; a < NUM_ANT; a++) begin
            for (int c = 0; c < NUM_CH; c++) begin
                next_sampled[a][c*SAMPLER_W+COS_LSB +: 2] =
                    quantise(cos_sample[a*NUM_CH+c], rms_level[a*NUM_CH+c],
                             walsh_reverse[a]);
                next_sampled[a][c*SAMPLER_W+SIN_LSB +: 2] =
                    quantise(sin_sample[a*NUM_CH+c], rms_level[a*NUM_CH+c],
                             walsh_reverse[a]);
            end
        end
    end

    // A second stage stands for the move onto the common clock.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sampled <= '0;
            retimed <= '0;
        end else begin
            sampled <= next_sampled;
            retimed <= sampled;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Coarse delay, one line per antenna sharing one sample pointer.

    logic [SAMP_PTR_W-1:0] samp_ptr;
    logic [NUM_ANT-1:0][ANT_W-1:0] delayed;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) samp_ptr <= '0;
        else samp_ptr <= samp_ptr + 1'b1;
    end

    for (genvar g = 0; g < NUM_ANT; g++) begin : g_delay
        coarse_delay u_delay (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .din(retimed[g]),
            .dout(delayed[g]),
            .samp_ptr(samp_ptr),
            .delay(coarse[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Multipliers. Cross index: pair*16 + freq*8 + pol*2 + kind.

    logic [1:0] inc [NUM_CNT];

    always_comb begin
        int p;
        int base;
        int ci;
        int cj;
        p = 0;
        base = 0;
        ci = 0;
        cj = 0;
        for (int i = 0; i < NUM_ANT; i++) begin
            for (int j = i + 1; j < NUM_ANT; j++) begin
                for (int f = 0; f < 2; f++) begin
                    for (int pol = 0; pol < 4; pol++) begin
                        // Channels A,B carry one hand; C,D the other.
                        ci = (pol == left_left_product || pol == left_right_product)
                             ? f : f + 2;
                        cj = (pol == left_left_product || pol == right_left_product)
                             ? f : f + 2;
                        base = p * CROSS_PER_PAIR + f * 8 + pol * 2;
                        inc[base] = prod_count(
                            delayed[i][ci*SAMPLER_W+SIN_LSB +: 2],
                            delayed[j][cj*SAMPLER_W+SIN_LSB +: 2]);
                        inc[base+1] = prod_count(
                            delayed[i][ci*SAMPLER_W+SIN_LSB +: 2],
                            delayed[j][cj*SAMPLER_W+COS_LSB +: 2]);
                    end
                end
                p++;
            end
        end
        // Self products square each component.
        for (int a = 0; a < NUM_ANT; a++) begin
            for (int k = 0; k < SELF_PER_ANT; k++) begin
                inc[NUM_CROSS+a*SELF_PER_ANT+k] = prod_count(
                    delayed[a][k*2 +: 2], delayed[a][k*2 +: 2]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Integration timer and counters.

    logic [CNT_W-1:0] integ_cnt;
    logic [CNT_W-1:0] mult_count;
    logic [CNT_W-1:0] cnt [NUM_CNT];
    logic [CNT_W-1:0] shadow [NUM_CNT];
    wire snap = integ_cnt == CNT_W'(INTEG_CYCLE_CLKS - 1);

    always_ff @(posedge clk_sys) begin
        if (sys_rst || snap) integ_cnt <= '0;
        else integ_cnt <= integ_cnt + 1'b1;
    end

    // Snap copies count plus this clock's product, then clears.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mult_count <= '0;
            for (int k = 0; k < NUM_CNT; k++) cnt[k] <= '0;
        end else begin
            if (snap) mult_count <= integ_cnt + 1'b1;
            for (int k = 0; k < NUM_CNT; k++) begin
                cnt[k] <= snap ? '0 : cnt[k] + CNT_W'(inc[k]);
            end
        end
    end

    // Shadow lets counting carry on while the controller drains.
    always_ff @(posedge clk_sys) begin
        if (snap) begin
            for (int k = 0; k < NUM_CNT; k++) shadow[k] <= cnt[k] + CNT_W'(inc[k]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-out walk: header word with the multiplication count, then
    // every counter in index order.

    typedef enum {WALK_IDLE, WALK_RUN} walk_e;
    walk_e walk;
    logic [IDX_W-1:0] walk_idx;

    stream_if #(.WIDTH(DUMP_W)) fill_if ();
    stream_if #(.WIDTH(DUMP_W)) drain_if ();

    assign fill_if.valid = walk == WALK_RUN;
    assign fill_if.data = (walk_idx == '0) ? {1'b1, mult_count}
                        : {1'b0, shadow[walk_idx - 1'b1]};
    wire push = fill_if.valid && fill_if.ready;
    wire walk_last = walk_idx == IDX_W'(NUM_CNT);

    // A full FIFO stalls the walk; a new snap restarts it.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            walk <= WALK_IDLE;
            walk_idx <= '0;
            dump_overrun <= 1'b0;
        end else begin
            dump_overrun <= snap && walk == WALK_RUN;
            if (snap) begin
                walk <= WALK_RUN;
                walk_idx <= '0;
            end else if (push) begin
                walk_idx <= walk_idx + 1'b1;
                if (walk_last) walk <= WALK_IDLE;
            end
        end
    end

    sample_fifo #(.WIDTH(DUMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr(fill_if),
        .rd(drain_if)
    );

    ////////////////////////////////////////////////////////////////////
    // Output register so the read-out ports come from flip-flops.

    assign drain_if.ready = !dump_valid || dump_ready;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dump_valid <= 1'b0;
            dump_first <= 1'b0;
            dump_data <= '0;
        end else if (drain_if.ready) begin
            dump_valid <= drain_if.valid;
            if (drain_if.valid) {dump_first, dump_data} <= drain_if.data;
        end
    end
endmodule : correlator_top
`default_nettype wire

// file: inc/corr_pkg.sv
// Constants, types and helpers for the delay and multiplier correlator.
// Assumes one sample clock; every clk_sys edge is one sample of every stream.
// Functional notes
// - Cosine and sine quantise at +-0.612 rms into two-bit three-level codes.
// - Coarse delay steps by one system clock period.
// - Sampler clock phase shifts in sixteenths of a period, 1250 ps each.
// - Sampler streams are retimed onto the system clock before coarse delay.
// - Walsh reversal inverts each sample's sign bit inside the sampler.
// - Each sampler delivers four parallel bit streams at the sample rate.
// - Delay demultiplexes each stream into sixteen lanes, then recombines it.
// - Stores of 256 and 512 words give about 328 us delay range.
// - Products -1, 0, +1 count as 0, 1, 2 so counters only increment.
// - Controller subtracts the multiplication count from each unsigned counter.
// - Counters are handed over once every 52 ms waveguide cycle.
// - Sixteen cross multipliers per pair: two frequencies, four polarisation pairs.
// - At most 12 antennas are supported.
// - Eight self multipliers per antenna, one per component, measure level setting.
package corr_pkg;
    localparam int NUM_ANT = 12;
    localparam int ANT_IDX_W = 4;
    localparam int NUM_CH = 4;
    localparam int NUM_PAIR = NUM_ANT * (NUM_ANT - 1) / 2;
    localparam int CROSS_PER_PAIR = 16;
    localparam int SELF_PER_ANT = 8;
    localparam int NUM_CROSS = NUM_PAIR * CROSS_PER_PAIR;
    localparam int NUM_CNT = NUM_CROSS + NUM_ANT * SELF_PER_ANT;
    localparam int IDX_W = 11;
    localparam int SAMPLE_W = 8;
    localparam int RMS_W = 8;
    localparam int THR_W = 10;
    localparam logic [THR_W-1:0] THR_NUM = 10'h0273; // 627/1024 = 0.612.
    localparam int THR_SHIFT = 10;
    localparam int CODE_SIGN = 1;
    localparam int CODE_MAG = 0;
    localparam int SIN_LSB = 0;
    localparam int COS_LSB = 2;
    localparam int SAMPLER_W = 4;
    localparam int ANT_W = NUM_CH * SAMPLER_W;
    localparam int LANES = 16;
    localparam int LANE_W = 4;
    localparam int STORE_SMALL = 256;
    localparam int STORE_LARGE = 512;
    localparam int DELAY_WORDS = 2 * STORE_SMALL + STORE_LARGE;
    localparam int SAMP_PTR_W = 14;
    localparam logic [SAMP_PTR_W-1:0] DELAY_MIN = 14'h0010;
    localparam logic [SAMP_PTR_W-1:0] DELAY_MAX = 14'h3FE0;
    localparam int PHASE_W = 4;
    localparam int CLK_PERIOD_NS = 20;
    localparam int INTEG_MS = 52;
    localparam int INTEG_CLKS = INTEG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam int FIFO_DEPTH = 16;
    localparam int DUMP_W = CNT_W + 1;
    localparam logic [1:0] PROD_NEG = 2'h0;
    localparam logic [1:0] PROD_ZERO = 2'h1;
    localparam logic [1:0] PROD_POS = 2'h2;

    typedef logic [1:0] code_t;
    typedef enum {left_left_product, right_right_product,
                  left_right_product, right_left_product} pol_e;

    // Three-level product mapped to a never-negative count.
    function automatic logic [1:0] prod_count(input code_t a, input code_t b);
        if (!a[CODE_MAG] || !b[CODE_MAG]) return PROD_ZERO;
        return (a[CODE_SIGN] ^ b[CODE_SIGN]) ? PROD_NEG : PROD_POS;
    endfunction : prod_count

    // Quantise one sample; walsh high flips the sign bit.
    function automatic code_t quantise(input logic [SAMPLE_W-1:0] s,
                                       input logic [RMS_W-1:0] rms,
                                       input logic walsh);
        logic [RMS_W+THR_W-1:0] p;
        logic signed [SAMPLE_W+1:0] sx;
        logic signed [SAMPLE_W+1:0] tx;
        p = RMS_W'(rms) * THR_NUM;
        sx = {{2{s[SAMPLE_W-1]}}, s};
        tx = {2'b00, p[THR_SHIFT +: RMS_W]};
        return {s[SAMPLE_W-1] ^ walsh, (sx > tx) || (sx < -tx)};
    endfunction : quantise
endpackage : corr_pkg

// file: inc/stream_if.sv
// Valid/ready word stream between the correlator's own modules.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// file: rtl/sample_fifo.sv
// Synchronous FIFO for the counter read-out stream.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Fill and drain sides
    stream_if.snk wr,
    stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
    wire push = wr.valid && wr.ready;
    wire pop = rd.valid && rd.ready;

    // Full and empty come straight from the fill level.
    assign wr.ready = fill != (AW+1)'(DEPTH);
    assign rd.valid = fill != '0;
    assign rd.data = mem[rp];

    // Storage has no reset; only pointers matter.
    always_ff @(posedge clk_sys) begin
        if (push) mem[wp] <= wr.data;
    end

    // Pointers wrap at DEPTH, which need not be a power of two.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wp <= '0;
            rp <= '0;
            fill <= '0;
        end else begin
            if (push) wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            if (pop) rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sample_fifo
`default_nettype wire

// file: rtl/coarse_delay.sv
// Coarse delay line for one antenna's sixteen retimed bit streams.
// Assumes samp_ptr counts up by one every clock, shared by all antennas.
`timescale 1ns/1ps
`default_nettype none
module coarse_delay (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Stream in and out
    input wire logic [corr_pkg::ANT_W-1:0] din,
    output logic [corr_pkg::ANT_W-1:0] dout,
    // Timing
    input wire logic [corr_pkg::SAMP_PTR_W-1:0] samp_ptr,
    input wire logic [corr_pkg::SAMP_PTR_W-1:0] delay
);
    import corr_pkg::*;
    localparam int WORD_W = SAMP_PTR_W - LANE_W;

    // Words of sixteen samples, written once per sixteen clocks.
    logic [LANES-1:0][ANT_W-1:0] store [DELAY_WORDS];
    logic [LANES-1:0][ANT_W-1:0] gather;
    wire [LANE_W-1:0] lane = samp_ptr[LANE_W-1:0];
    wire [WORD_W-1:0] word = samp_ptr[SAMP_PTR_W-1:LANE_W];
    wire word_done = lane == LANE_W'(LANES - 1);
    wire [SAMP_PTR_W-1:0] rd_ptr = samp_ptr - delay - DELAY_MIN;
    wire [LANES*ANT_W-1:0] full_word = {din, gather[LANES-2:0]};

    // Demultiplex: a slow write enable stores the whole lane word.
    always_ff @(posedge clk_sys) begin
        gather[lane] <= din;
        if (word_done) store[word] <= full_word;
    end

    // Recombine by picking one lane of a past word each clock.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) dout <= '0;
        else dout <= store[rd_ptr[SAMP_PTR_W-1:LANE_W]][rd_ptr[LANE_W-1:0]];
    end
endmodule : coarse_delay
`default_nettype wire

// file: verification/correlator_top_asserts.sv
// Port checker for correlator_top: read-out handshake and delay loading.
// Assumes one clk_sys domain; bound to the top by the statement at the end.
`timescale 1ns/1ps
`default_nettype none
module correlator_top_asserts #(
    parameter int INTEG_CYCLE_CLKS = 64
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Delay loading
    input wire logic delay_load,
    input wire logic [corr_pkg::ANT_IDX_W-1:0] delay_ant,
    input wire logic [corr_pkg::PHASE_W-1:0] delay_fine,
    input wire logic [corr_pkg::NUM_ANT-1:0][corr_pkg::PHASE_W-1:0] sampler_phase,
    // Read-out
    input wire logic dump_valid,
    input wire logic dump_first,
    input wire logic [corr_pkg::CNT_W-1:0] dump_data,
    input wire logic dump_ready,
    input wire logic dump_overrun
);
    import corr_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // A stalled word must not move, or the controller would lose a count.
    AST_DUMP_HOLD: assert property (
        dump_valid && !dump_ready |=> dump_valid && $stable(dump_data) && $stable(dump_first))
        else $error("Stalled word changed.");
    AST_HDR_VALUE: assert property (
        dump_valid && dump_first |-> dump_data == CNT_W'(INTEG_CYCLE_CLKS))
        else $error("Wrong header count.");
    AST_CNT_RANGE: assert property (
        dump_valid && !dump_first |-> dump_data <= CNT_W'(2 * INTEG_CYCLE_CLKS))
        else $error("Counter too large.");
    AST_PHASE_LOAD: assert property (
        delay_load && int'(delay_ant) < NUM_ANT
        |=> sampler_phase[$past(delay_ant)] == $past(delay_fine))
        else $error("Fine phase not loaded.");
    AST_PHASE_KEEP: assert property (
        !delay_load || int'(delay_ant) >= NUM_ANT |=> $stable(sampler_phase))
        else $error("Phase changed without load.");
    AST_QUIET_START: assert property (
        $fell(sys_rst) |-> !dump_valid [*8])
        else $error("Early read-out.");
    AST_HDR_NEXT: assert property (
        dump_valid && dump_first && dump_ready |=> ##[0:16] (dump_valid && !dump_first))
        else $error("No word after header.");
    AST_OVR_PULSE: assert property (
        dump_overrun |=> !dump_overrun)
        else $error("Overrun too long.");
    COV_HDR: cover property (dump_valid && dump_first && dump_ready);
    COV_STALL: cover property (dump_valid && !dump_ready);
    COV_LOAD: cover property (delay_load);
    COV_OVR: cover property (dump_overrun);
endmodule : correlator_top_asserts
bind correlator_top correlator_top_asserts #(.INTEG_CYCLE_CLKS(INTEG_CYCLE_CLKS))
    correlator_top_asserts_i (.*);
`default_nettype wire

// file: verification/dump_ctrl_model.sv
// Controller model: takes read-out words and keeps the last whole block.
// Assumes one clk_sys; the bench sets the pace of dump_ready.
`timescale 1ns/1ps
`default_nettype none
module dump_ctrl_model (
    // Clock and pace
    input wire logic clk_sys,
    input wire logic [1:0] pace,
    // Read-out stream
    input wire logic dump_valid,
    input wire logic dump_first,
    input wire logic [corr_pkg::CNT_W-1:0] dump_data,
    output logic dump_ready
);
    import corr_pkg::*;
    logic [DUMP_W-1:0] blk [NUM_CNT+1];
    longint acc [NUM_CNT];
    int n_words = 0;
    int n_blocks = 0;
    logic [2:0] tick = 3'h0;
    ////////////////////////////////////////////////////////////
    // Pace 1 stalls one cycle in eight; pace 2 takes one word in eight.
    initial dump_ready = 1'b1;
    always @(negedge clk_sys) begin
        tick = tick + 3'h1;
        dump_ready = (pace == 2'h0) || (pace == 2'h1 ? tick != 3'h0 : tick == 3'h0);
    end
    // A header restarts the block; six-block sums keep the signed result.
    always @(posedge clk_sys) begin
        if (dump_valid && dump_ready) begin
            if (dump_first) n_words = 0;
            if (n_words <= NUM_CNT) blk[n_words] = {dump_first, dump_data};
            n_words++;
            if (n_words == NUM_CNT + 1) begin
                for (int k = 0; k < NUM_CNT; k++) begin
                    acc[k] = (n_blocks % 6 == 0) ? 0 : acc[k];
                    acc[k] += longint'(blk[k+1][CNT_W-1:0]) - longint'(blk[0][CNT_W-1:0]);
                end
                n_blocks++;
            end
        end
    end
endmodule : dump_ctrl_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for correlator_top with an integer counter model.
// Assumes a short integration cycle; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import corr_pkg::*;
    localparam int N_INTEG = 2000;
    localparam int NS = NUM_ANT * NUM_CH;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [NS-1:0][SAMPLE_W-1:0] cos_sample = '0;
    logic [NS-1:0][SAMPLE_W-1:0] sin_sample = '0;
    logic [NS-1:0][RMS_W-1:0] rms_level = '0;
    logic [NUM_ANT-1:0] walsh_reverse = '0;
    logic delay_load = 1'b0;
    logic [ANT_IDX_W-1:0] delay_ant = '0;
    logic [SAMP_PTR_W-1:0] delay_coarse = '0;
    logic [PHASE_W-1:0] delay_fine = '0;
    logic [NUM_ANT-1:0][PHASE_W-1:0] sampler_phase;
    logic dump_valid;
    logic dump_first;
    logic [CNT_W-1:0] dump_data;
    logic dump_ready;
    logic dump_overrun;
    logic [1:0] pace = 2'h1;
    logic dmode = 1'b0;
    logic [15:0] seed = 16'h0011;
    int n_errors = 0;
    int tests_run = 0;
    int n_ovr = 0;
    int n0 = 0;
    int cyc = 0;
    int sc [NS];
    int cc [NS];
    int eff [NUM_ANT];
    logic [PHASE_W-1:0] ph [NUM_ANT];
    logic [DUMP_W-1:0] expv [NUM_CNT+1];
    correlator_top #(.INTEG_CYCLE_CLKS(N_INTEG)) correlator_top_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .cos_sample(cos_sample), .sin_sample(sin_sample),
        .rms_level(rms_level), .walsh_reverse(walsh_reverse), .delay_load(delay_load),
        .delay_ant(delay_ant), .delay_coarse(delay_coarse), .delay_fine(delay_fine),
        .sampler_phase(sampler_phase), .dump_valid(dump_valid), .dump_first(dump_first),
        .dump_data(dump_data), .dump_ready(dump_ready), .dump_overrun(dump_overrun));
    dump_ctrl_model dump_ctrl_model_i (.clk_sys(clk_sys), .pace(pace), .dump_valid(dump_valid),
        .dump_first(dump_first), .dump_data(dump_data), .dump_ready(dump_ready));
    ////////////////////////////////////////////////////////////
    // Clock, delay-test sign pattern of period four, overrun count.
    initial forever #10 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        cyc++;
        if (dmode) for (int k = 0; k < NS; k++) begin
            sin_sample[k] = (cyc & 2) ? 8'h9C : 8'h64;
            cos_sample[k] = (cyc & 2) ? 8'h9C : 8'h64;
        end
    end
    always @(posedge clk_sys) if (dump_overrun === 1'b1) n_ovr++;
    // Model: random bytes, code {sign, mag}, product count.
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd
    function automatic int qz(logic [7:0] s, logic [7:0] r, logic w);
        int x;
        int t;
        x = int'($signed(s));
        t = (int'(r) * int'(THR_NUM)) >> THR_SHIFT;
        return ((s[7] ^ w) ? 2 : 0) + (((x > t) || (x < -t)) ? 1 : 0);
    endfunction : qz
    function automatic int pr(int a, int b);
        if (a % 2 == 0 || b % 2 == 0) return 1;
        return (a / 2 == b / 2) ? 2 : 0;
    endfunction : pr
    // Delay test: the delay difference modulo four sets the product.
    function automatic int xp(int i, int ci, int j, int cj, int kind);
        int d;
        d = (((eff[i] - eff[j]) % 4) + 4) % 4;
        if (dmode) return (d == 0) ? 2 : (d == 2) ? 0 : 1;
        return pr(sc[i*4+ci], kind ? cc[j*4+cj] : sc[j*4+cj]);
    endfunction : xp
    task automatic cmp_word(logic [DUMP_W-1:0] got, logic [DUMP_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_small(logic [3:0] got, logic [3:0] exp);
        cmp_word(DUMP_W'(got), DUMP_W'(exp));
    endtask : cmp_small
    task automatic build_exp();
        int p;
        int f;
        int o;
        int li;
        int lj;
        p = 0;
        expv[0] = {1'b1, CNT_W'(N_INTEG)};
        for (int i = 0; i < NUM_ANT; i++) begin
            for (int j = i + 1; j < NUM_ANT; j++) begin
                for (int q = 0; q < CROSS_PER_PAIR; q++) begin
                    f = (q >> 3) & 1;
                    o = (q >> 1) & 3;
                    li = (o == 1 || o == 3) ? 2 + f : f;
                    lj = (o == 1 || o == 2) ? 2 + f : f;
                    expv[1+p*16+q] = {1'b0, CNT_W'(N_INTEG * xp(i, li, j, lj, q & 1))};
                end
                p++;
            end
        end
        for (int a = 0; a < NUM_ANT; a++) begin
            for (int q = 0; q < SELF_PER_ANT; q++) begin
                o = (q % 2) ? cc[a*4+q/2] : sc[a*4+q/2];
                expv[1+NUM_CROSS+a*8+q] = {1'b0, CNT_W'(N_INTEG * (dmode ? 2 : pr(o, o)))};
            end
        end
    endtask : build_exp
    // Mode 0: free samples; mode 1: on or just past the threshold.
    task automatic set_phase(int mode, logic [NUM_ANT-1:0] wal);
        int t;
        logic [7:0] r;
        logic [7:0] s;
        logic [7:0] c;
        @(negedge clk_sys);
        walsh_reverse = wal;
        for (int k = 0; k < NS; k++) begin
            r = rnd();
            s = rnd();
            c = rnd();
            if (mode == 1) begin
                r = r & 8'h7F;
                t = (int'(r) * int'(THR_NUM)) >> THR_SHIFT;
                s = 8'(s[0] ? -(t + int'(s[1])) : t + int'(s[1]));
                c = 8'(c[0] ? -(t + int'(c[1])) : t + int'(c[1]));
            end
            rms_level[k] = r;
            sin_sample[k] = s;
            cos_sample[k] = c;
            sc[k] = qz(s, r, wal[k/4]);
            cc[k] = qz(c, r, wal[k/4]);
        end
        build_exp();
    endtask : set_phase
    task automatic wait_blocks(int n);
        int t;
        t = dump_ctrl_model_i.n_blocks + n;
        wait (dump_ctrl_model_i.n_blocks >= t);
    endtask : wait_blocks
    task automatic check_block(string name);
        for (int k = 0; k <= NUM_CNT; k++) cmp_word(dump_ctrl_model_i.blk[k], expv[k]);
        $display("test %s done", name);
    endtask : check_block
    // Strobe stays high across back-to-back loads; the caller drops it.
    task automatic ld(int a, int c, int f);
        @(negedge clk_sys);
        delay_load = 1'b1;
        delay_ant = 4'(a);
        delay_coarse = 14'(c);
        delay_fine = 4'(f);
    endtask : ld
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////
    // Delay memory holds stale data at first, so checking starts late.
    initial begin
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        for (int a = 0; a < NUM_ANT; a++) cmp_small(sampler_phase[a], 4'h0);
        cmp_small({3'h0, dump_valid}, 4'h0);
        wait_blocks(9);
        set_phase(0, '0);
        wait_blocks(3);
        check_block("random");
        set_phase(0, 12'({rnd(), rnd()}));
        wait_blocks(3);
        check_block("walsh");
        set_phase(1, '0);
        wait_blocks(3);
        check_block("threshold");
        @(negedge clk_sys);
        dmode = 1'b1;
        walsh_reverse = '0;
        rms_level = '0;
        for (int a = 0; a < NUM_ANT; a++) begin
            ph[a] = 4'(rnd());
            eff[a] = (a == 3) ? int'(DELAY_MAX) : a;
            ld(a, (a == 3) ? 16383 : a, ph[a]);
        end
        ld(13, 5, 15);
        @(negedge clk_sys);
        delay_load = 1'b0;
        @(negedge clk_sys);
        for (int a = 0; a < NUM_ANT; a++) cmp_small(sampler_phase[a], ph[a]);
        build_exp();
        wait_blocks(11);
        check_block("delay");
        cmp_small(4'(n_ovr), 4'h0);
        n0 = n_ovr;
        pace = 2'h2;
        repeat (3 * N_INTEG) @(negedge clk_sys);
        cmp_small(4'(n_ovr - n0 >= 2), 4'h1);
        $display("test overrun done");
        tally_and_finish();
    end
    initial begin
        repeat (48 * N_INTEG) @(posedge clk_sys);
        n_errors++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
